// file: hdl/cell_extract_pkg.sv
// Constants shared by the cell extraction buffer design.
package cell_extract_pkg;
  // Register offsets within the device's 8-bit register window.
  localparam logic [7:0] INT_STATUS_OFFSET  = 8'h0b;
  localparam logic [7:0] INT_ENABLE_OFFSET  = 8'h0f;
  localparam logic [7:0] MEM_CONTROL_OFFSET = 8'h13;
  localparam logic [7:0] DATA_BYTE3_OFFSET  = 8'h14;
  localparam logic [7:0] DATA_BYTE2_OFFSET  = 8'h15;
  localparam logic [7:0] DATA_BYTE1_OFFSET  = 8'h16;
  localparam logic [7:0] DATA_BYTE0_OFFSET  = 8'h17;
  // Field positions.
  localparam int INSERT_SOC_BIT       = 0;
  localparam int INSERT_SPACE_BIT     = 1;
  localparam int INSERT_RESET_N_BIT   = 2;
  localparam int EXTRACT_READY_BIT    = 3;
  localparam int EXTRACT_RESET_N_BIT  = 4;
  localparam int EXTRACT_INT_BIT      = 5;
  // Reset values.
  localparam logic [7:0] MEM_CONTROL_RESET = 8'h14;
  localparam logic [7:0] INT_ENABLE_RESET  = 8'h00;
  // Cell shape: 56 bytes read as 14 words of 32 bits; then cells stored and host buffer entries.
  localparam int CELL_WORDS   = 14;
  localparam int WORD_BITS    = 32;
  localparam int CELL_DEPTH   = 2;
  localparam int BUF_ENTRIES  = 2;
endpackage

// file: hdl/word_stream_if.sv
// Valid/ready word stream used between the cell store, the skid buffer and the host readout.
`timescale 1ns/1ps
interface word_stream_if #(parameter int WIDTH = 32);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// file: hdl/word_skid_buffer.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module word_skid_buffer #(
  parameter int WIDTH   = 32,
  parameter int ENTRIES = 2
) (
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  input  wire logic   flush,
  word_stream_if.dst  in_s,
  word_stream_if.src  out_s
);
  import cell_extract_pkg::*;
  localparam int PW = $clog2(ENTRIES);

  logic [WIDTH-1:0] mem_reg [ENTRIES];
  logic [PW-1:0]    wr_reg;
  logic [PW-1:0]    rd_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(ENTRIES - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_s.ready  = (count_reg != (PW+1)'(ENTRIES));
  assign out_s.valid = (count_reg != '0);
  assign out_s.data  = mem_reg[rd_reg];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_s.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= bump(wr_reg);
      end
      if (pop) begin
        rd_reg <= bump(rd_reg);
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // word_skid_buffer

// file: hdl/cell_extract_buffer.sv
// Transmit cell extraction buffer with byte-wide microprocessor register access.
`timescale 1ns/1ps
module cell_extract_buffer #(
  parameter int CELLS = cell_extract_pkg::CELL_DEPTH
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic        cs_n,
  input  wire logic        wr_n,
  input  wire logic        rd_n,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  output logic             int_n,
  input  wire logic        filt_valid,
  input  wire logic        filt_sof,
  input  wire logic [31:0] filt_data,
  output logic             filt_ready,
  output logic             insert_strobe,
  output logic             insert_sof,
  output logic      [31:0] insert_data
);
  import cell_extract_pkg::*;

  // ************************************************************
  // Pin synchronisation and access strobes
  // ************************************************************
  logic [1:0] cs_sync_reg, wr_sync_reg, rd_sync_reg;
  logic [7:0] addr_s1_reg, addr_reg, wdata_s1_reg, wdata_reg;
  logic       wr_prev_reg, rd_prev_reg;
  logic       wr_pulse, rd_pulse;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_reg  <= 2'h3;
      wr_sync_reg  <= 2'h3;
      rd_sync_reg  <= 2'h3;
      addr_s1_reg  <= 8'h00;
      addr_reg     <= 8'h00;
      wdata_s1_reg <= 8'h00;
      wdata_reg    <= 8'h00;
      wr_prev_reg  <= 1'b0;
      rd_prev_reg  <= 1'b0;
    end else begin
      cs_sync_reg  <= {cs_sync_reg[0], cs_n};
      wr_sync_reg  <= {wr_sync_reg[0], wr_n};
      rd_sync_reg  <= {rd_sync_reg[0], rd_n};
      addr_s1_reg  <= addr;
      addr_reg     <= addr_s1_reg;
      wdata_s1_reg <= wdata;
      wdata_reg    <= wdata_s1_reg;
      wr_prev_reg  <= ~cs_sync_reg[1] & ~wr_sync_reg[1];
      rd_prev_reg  <= ~cs_sync_reg[1] & ~rd_sync_reg[1];
    end
  end

  // Strobes act once, at the leading edge of each access, after synchronisation.
  assign wr_pulse = ~cs_sync_reg[1] & ~wr_sync_reg[1] & ~wr_prev_reg;
  assign rd_pulse = ~cs_sync_reg[1] & ~rd_sync_reg[1] & ~rd_prev_reg;

  // ************************************************************
  // Control and interrupt registers
  // ************************************************************
  logic [7:0] control_reg;
  logic       int_enable_reg;
  logic       int_status_reg;
  logic       flush;
  logic       cell_loaded;

  // Flush on the rising write of the active-low reset bit.
  assign flush = wr_pulse && addr_reg == MEM_CONTROL_OFFSET &&
                 wdata_reg[EXTRACT_RESET_N_BIT] && !control_reg[EXTRACT_RESET_N_BIT];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg <= MEM_CONTROL_RESET;
    end else if (wr_pulse && addr_reg == MEM_CONTROL_OFFSET) begin
      control_reg <= wdata_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_enable_reg <= 1'b0;
    end else if (wr_pulse && addr_reg == INT_ENABLE_OFFSET) begin
      int_enable_reg <= wdata_reg[EXTRACT_INT_BIT];
    end
  end

  // Reading the status register clears it, but a new cell in that cycle wins while the interrupt is enabled.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_status_reg <= 1'b0;
    end else if (cell_loaded && int_enable_reg) begin
      int_status_reg <= 1'b1;
    end else if (rd_pulse && addr_reg == INT_STATUS_OFFSET) begin
      int_status_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~(int_status_reg & int_enable_reg);
    end
  end

  // ************************************************************
  // Cell store fed by the user cell filter
  // ************************************************************
  localparam int SLOTS = CELLS * CELL_WORDS;
  localparam int AW    = $clog2(SLOTS);
  localparam int WW    = $clog2(CELL_WORDS);

  logic [31:0]   store_reg [SLOTS];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [WW-1:0] wr_word_reg;
  logic [2:0]    cells_reg;
  logic          wr_active_reg;
  logic          store_push;
  logic          store_pop;
  logic          cell_read;
  logic [WW-1:0] rd_word_reg;

  function automatic logic [AW-1:0] next_slot(input logic [AW-1:0] p);
    return (p == AW'(SLOTS - 1)) ? '0 : p + 1'b1;
  endfunction

  word_stream_if #(.WIDTH(WORD_BITS)) store_s ();
  word_stream_if #(.WIDTH(WORD_BITS)) host_s ();

  // A cell is accepted only whole: the filter is stalled while no cell slot is free,
  // so a partial cell is never stored.
  assign filt_ready = (wr_active_reg || filt_sof) && (cells_reg < 3'(CELLS)) &&
                      !(wr_active_reg == 1'b0 && cells_reg + 3'(1) > 3'(CELLS));
  assign store_push = filt_valid && filt_ready;
  assign cell_loaded = store_push && wr_word_reg == WW'(CELL_WORDS - 1);

  always_ff @(posedge sys_clk) begin
    if (store_push) begin
      store_reg[wr_ptr_reg] <= filt_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg    <= '0;
      wr_word_reg   <= '0;
      wr_active_reg <= 1'b0;
    end else if (flush) begin
      wr_ptr_reg    <= '0;
      wr_word_reg   <= '0;
      wr_active_reg <= 1'b0;
    end else if (store_push) begin
      wr_ptr_reg    <= next_slot(wr_ptr_reg);
      wr_active_reg <= !cell_loaded;
      wr_word_reg   <= cell_loaded ? '0 : wr_word_reg + 1'b1;
    end
  end

  // Store output streams words into the two-entry buffer toward the host.
  logic [AW:0] stored_words_reg;
  assign store_s.valid = stored_words_reg != '0 && !flush;
  assign store_s.data  = store_reg[rd_ptr_reg];
  assign store_pop     = store_s.valid && store_s.ready;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_reg       <= '0;
      stored_words_reg <= '0;
    end else if (flush) begin
      rd_ptr_reg       <= '0;
      stored_words_reg <= '0;
    end else begin
      if (store_pop) begin
        rd_ptr_reg <= next_slot(rd_ptr_reg);
      end
      stored_words_reg <= stored_words_reg + (AW+1)'(cell_loaded ? CELL_WORDS : 0)
                          - (AW+1)'(store_pop);
    end
  end

  word_skid_buffer #(.WIDTH(WORD_BITS), .ENTRIES(BUF_ENTRIES)) u_skid (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .flush   (flush),
    .in_s    (store_s),
    .out_s   (host_s)
  );

  // ************************************************************
  // Host readout: byte 0 read completes a word
  // ************************************************************
  assign host_s.ready = rd_pulse && addr_reg == DATA_BYTE0_OFFSET;
  assign cell_read    = host_s.ready && host_s.valid && rd_word_reg == WW'(CELL_WORDS - 1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_word_reg <= '0;
    end else if (flush) begin
      rd_word_reg <= '0;
    end else if (host_s.ready && host_s.valid) begin
      rd_word_reg <= cell_read ? '0 : rd_word_reg + 1'b1;
    end
  end

  // Count of complete unread cells; a load and a finished read may coincide.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cells_reg <= '0;
    end else if (flush) begin
      cells_reg <= '0;
    end else begin
      cells_reg <= cells_reg + 3'(cell_loaded) - 3'(cell_read);
    end
  end

  // ************************************************************
  // Read data mux
  // ************************************************************
  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = 8'h00;
    unique case (addr_reg)
      MEM_CONTROL_OFFSET: begin
        rdata_next = control_reg & 8'h17;
        rdata_next[EXTRACT_READY_BIT] = cells_reg != '0;
      end
      INT_ENABLE_OFFSET: rdata_next[EXTRACT_INT_BIT] = int_enable_reg;
      INT_STATUS_OFFSET: rdata_next[EXTRACT_INT_BIT] = int_status_reg;
      // Data registers always read the extraction side.
      DATA_BYTE3_OFFSET: rdata_next = host_s.data[31:24];
      DATA_BYTE2_OFFSET: rdata_next = host_s.data[23:16];
      DATA_BYTE1_OFFSET: rdata_next = host_s.data[15:8];
      DATA_BYTE0_OFFSET: rdata_next = host_s.data[7:0];
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_next;
    end
  end

  // ************************************************************
  // Insertion word assembly passed to the insertion side
  // ************************************************************
  logic [23:0] insert_hold_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      insert_hold_reg <= 24'h000000;
      insert_strobe   <= 1'b0;
      insert_sof      <= 1'b0;
      insert_data     <= 32'h00000000;
    end else begin
      insert_strobe <= 1'b0;
      if (wr_pulse) begin
        unique case (addr_reg)
          DATA_BYTE3_OFFSET: insert_hold_reg[23:16] <= wdata_reg;
          DATA_BYTE2_OFFSET: insert_hold_reg[15:8]  <= wdata_reg;
          DATA_BYTE1_OFFSET: insert_hold_reg[7:0]   <= wdata_reg;
          DATA_BYTE0_OFFSET: begin
            // Each byte-0 write completes one word; 13 follow the first.
            insert_strobe <= 1'b1;
            insert_sof    <= control_reg[INSERT_SOC_BIT];
            insert_data   <= {insert_hold_reg, wdata_reg};
          end
          default: insert_strobe <= 1'b0;
        endcase
      end
    end
  end
endmodule // cell_extract_buffer

// file: test/cell_filter_model.sv
// Behavioural user cell filter that feeds copied cells into the extraction buffer.
`timescale 1ns/1ps
module cell_filter_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [7:0]  seed,
  input  wire logic        filt_ready,
  output logic             filt_valid,
  output logic             filt_sof,
  output logic      [31:0] filt_data,
  output logic             busy
);
  logic [3:0] word_reg;
  // Byte n of a cell is seed plus n, so header, HEC, user and payload bytes run in order.
  function automatic logic [31:0] word_of(input logic [3:0] k);
    return {seed + {k, 2'd0}, seed + {k, 2'd1}, seed + {k, 2'd2}, seed + {k, 2'd3}};
  endfunction
  // In slow mode released data is inverted so that a stale word can never pass for a fresh one.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_valid <= 1'b0;
      filt_sof   <= 1'b0;
      filt_data  <= 32'h0;
      busy       <= 1'b0;
      word_reg   <= 4'h0;
    end else if (filt_valid && filt_ready) begin
      word_reg   <= word_reg + 4'h1;
      busy       <= word_reg != 4'hd;
      filt_sof   <= 1'b0;
      filt_valid <= !slow && word_reg != 4'hd;
      filt_data  <= slow ? ~filt_data : word_of(word_reg + 4'h1);
    end else if (busy && !filt_valid) begin
      filt_valid <= 1'b1;
      filt_data  <= word_of(word_reg);
    end else if (go && !busy) begin
      busy       <= 1'b1;
      word_reg   <= 4'h0;
      filt_valid <= 1'b1;
      filt_sof   <= 1'b1;
      filt_data  <= word_of(4'h0);
    end
  end
endmodule // cell_filter_model

// file: test/cell_extract_buffer_sva.sv
// Concurrent checks on the ports of the cell extraction buffer.
`timescale 1ns/1ps
module cell_extract_buffer_sva (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] addr,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic [7:0] rdata,
  input wire logic       int_n,
  input wire logic       filt_valid,
  input wire logic       filt_ready,
  input wire logic       insert_strobe
);
  import cell_extract_pkg::*;
  logic [3:0] since_hs_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Saturating count of cycles since the filter last handed over a word.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) since_hs_reg <= 4'hf;
    else if (filt_valid && filt_ready) since_hs_reg <= 4'h0;
    else if (since_hs_reg != 4'hf) since_hs_reg <= since_hs_reg + 4'h1;
  end
  AST_INT_FALL_CAUSE: assert property ($fell(int_n) |-> since_hs_reg < 4'h6)
    else $error("interrupt fell without a cell load");
  AST_INT_HOLD: assert property (((rd_n && wr_n) [*6] ##0 !int_n) |=> !int_n)
    else $error("interrupt released without host access");
  AST_INT_RESET_HIGH: assert property ($rose(rst_n) |-> int_n)
    else $error("interrupt low after reset");
  AST_READ_NO_INSERT: assert property (wr_n [*8] |-> !insert_strobe)
    else $error("insertion word without a write");
  AST_INSERT_ONE_PULSE: assert property (insert_strobe |=> !insert_strobe)
    else $error("insertion strobe longer than one cycle");
  AST_CTRL_STABLE: assert property ((addr == MEM_CONTROL_OFFSET && rd_n && wr_n && !filt_valid)
    [*8] |-> $stable(rdata))
    else $error("control value moved without cause");
  AST_CTRL_UNUSED_ZERO: assert property ((addr == MEM_CONTROL_OFFSET) [*6] |-> rdata[7:5] == 3'h0)
    else $error("unused control bits not zero");
  AST_UNMAPPED_ZERO: assert property ((addr == 8'h30) [*6] |-> rdata == 8'h00)
    else $error("unmapped address read not zero");
endmodule // cell_extract_buffer_sva
bind cell_extract_buffer cell_extract_buffer_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n),
  .addr(addr), .wr_n(wr_n), .rd_n(rd_n), .rdata(rdata), .int_n(int_n),
  .filt_valid(filt_valid), .filt_ready(filt_ready), .insert_strobe(insert_strobe));

// file: test/cell_extract_buffer_tb_top.sv
// Self-checking testbench for the cell extraction buffer.
`timescale 1ns/1ps
module cell_extract_buffer_tb_top;
  import cell_extract_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] m; logic [7:0] w;} row_t;
  logic        sys_clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
  logic        go = 1'b0, slow = 1'b0, int_n, filt_valid, filt_sof, filt_ready, busy;
  logic        insert_strobe, insert_sof, ins_sof;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, seed = 8'h00, rdata, got;
  logic [31:0] filt_data, insert_data, ins_word;
  int          n_fail = 0, tests_run = 0;
  row_t        rows [9] = '{
    '{1'b0, MEM_CONTROL_OFFSET, 8'h00, 8'hff, MEM_CONTROL_RESET},
    '{1'b0, INT_ENABLE_OFFSET, 8'h00, 8'hff, INT_ENABLE_RESET},
    '{1'b0, INT_STATUS_OFFSET, 8'h00, 8'hff, 8'h00},
    '{1'b1, 8'h30, 8'ha5, 8'h00, 8'h00},
    '{1'b0, 8'h30, 8'h00, 8'hff, 8'h00},
    '{1'b1, MEM_CONTROL_OFFSET, 8'h04, 8'h00, 8'h00},
    '{1'b1, MEM_CONTROL_OFFSET, 8'h14, 8'h00, 8'h00},
    '{1'b1, INT_ENABLE_OFFSET, 8'h20, 8'h00, 8'h00},
    '{1'b0, INT_ENABLE_OFFSET, 8'h00, 8'h20, 8'h20}};
  cell_extract_buffer #(.CELLS(CELL_DEPTH)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .wdata(wdata), .rdata(rdata), .int_n(int_n),
    .filt_valid(filt_valid), .filt_sof(filt_sof), .filt_data(filt_data), .filt_ready(filt_ready),
    .insert_strobe(insert_strobe), .insert_sof(insert_sof), .insert_data(insert_data));
  cell_filter_model u_filter (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .slow(slow),
    .seed(seed), .filt_ready(filt_ready), .filt_valid(filt_valid), .filt_sof(filt_sof),
    .filt_data(filt_data), .busy(busy));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // The strobe lasts only one cycle, so the word is captured where it appears.
  always @(posedge sys_clk) begin
    if (insert_strobe === 1'b1) begin
      ins_word <= insert_data;
      ins_sof  <= insert_sof;
    end
  end
  // ********
  // Tasks
  // ********
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Pins are synchronised, so address and data settle well before the strobe and the
  // read value is taken before a byte-0 strobe can pop the word.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    cycles(8);
    got   = rdata;
    cs_n  <= 1'b0;
    wr_n  <= !wr;
    rd_n  <= wr;
    cycles(5);
    cs_n  <= 1'b1;
    wr_n  <= 1'b1;
    rd_n  <= 1'b1;
    cycles(4);
  endtask
  task automatic send(input logic [7:0] s, input logic sl);
    seed <= s;
    slow <= sl;
    go   <= 1'b1;
    cycles(1);
    go   <= 1'b0;
    cycles(1);
  endtask
  task automatic settle;
    for (int i = 0; i < 300 && busy !== 1'b0; i++) cycles(1);
    check("filter idle", busy, 1'b0);
  endtask
  // The flag is always read afresh, so a stale data byte can never stand in for it.
  task automatic flag(input logic want);
    bus(1'b0, MEM_CONTROL_OFFSET, 8'h00);
    for (int i = 0; i < 20 && got[EXTRACT_READY_BIT] !== want; i++) bus(1'b0, MEM_CONTROL_OFFSET, 8'h00);
    check("cell ready flag", got[EXTRACT_READY_BIT], want);
  endtask
  task automatic read_cell(input logic [7:0] s);
    for (int k = 0; k < CELL_WORDS; k++)
      for (int j = 0; j < 4; j++) begin
        bus(1'b0, DATA_BYTE3_OFFSET + 8'(j), 8'h00);
        check("cell byte", got, 8'(s + 8'(4 * k + j)));
      end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    cycles(6);
    rst_n <= 1'b1;
    cycles(2);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) check("register", got & rows[i].m, rows[i].w);
    end
    send(8'h10, 1'b0);
    settle();
    got = 8'h00;
    flag(1'b1);
    check("interrupt line", int_n, 1'b0);
    bus(1'b0, INT_STATUS_OFFSET, 8'h00);
    check("status set", got[EXTRACT_INT_BIT], 1'b1);
    bus(1'b0, INT_STATUS_OFFSET, 8'h00);
    check("status cleared", got[EXTRACT_INT_BIT], 1'b0);
    check("interrupt released", int_n, 1'b1);
    send(8'h80, 1'b1);
    settle();
    send(8'hc0, 1'b0);
    cycles(10);
    check("ready while full", filt_ready, 1'b0);
    read_cell(8'h10);
    flag(1'b1);
    bus(1'b1, MEM_CONTROL_OFFSET, 8'h15);
    for (int j = 0; j < 4; j++) bus(1'b1, DATA_BYTE3_OFFSET + 8'(j), 8'(j + 1));
    check("insertion word", ins_word, 32'h01020304);
    check("insertion start", ins_sof, 1'b1);
    read_cell(8'h80);
    settle();
    read_cell(8'hc0);
    flag(1'b0);
    send(8'h40, 1'b1);
    settle();
    flag(1'b1);
    bus(1'b1, MEM_CONTROL_OFFSET, 8'h04);
    bus(1'b1, MEM_CONTROL_OFFSET, 8'h14);
    flag(1'b0);
    rst_n <= 1'b0;
    cycles(2);
    check("interrupt in reset", int_n, 1'b1);
    rst_n <= 1'b1;
    cycles(2);
    end_sim();
  end
  initial begin
    cycles(40000);
    n_fail++;
    end_sim();
  end
endmodule // cell_extract_buffer_tb_top
